// >>> core/ids_defines.svh
// Purpose: constants for the instruction decode subset
// Assumes: 14-bit instruction words, 8-bit data
// Notes: opcode fields sit in instruction bits 13:8
`ifndef IDS_DEFINES_SVH
`define IDS_DEFINES_SVH
// ==========================================
// opcode fields, bits 13:8
`define IDS_OP_COPY 6'h08
`define IDS_OP_OR 6'h04
`define IDS_OP_ROTL 6'h0D
`define IDS_OP_ROTR 6'h0C
`define IDS_OP_INCSZ 6'h0F
// literal group: bits 13:12, then kind in 11:10 or 11:9
`define IDS_OP_LIT_HI 2'h3
`define IDS_LIT_LOAD 2'h0
`define IDS_LIT_RET 2'h1
`define IDS_LIT_SUB3 3'h6
// ==========================================
// whole-word encodings
`define IDS_W_RETI 14'h0009
`define IDS_W_RET 14'h0008
`define IDS_W_OPTION 14'h0062
`define IDS_W_SLEEP 14'h0063
`define IDS_W_NOP 14'h0000
// ==========================================
// reset values and timing
`define IDS_ACC_RST 8'h00
`define IDS_WDOG_CLEAR 8'h00
`define IDS_PHASES 2'h3
`define IDS_CLK_NS 20
`endif

// >>> core/ids_pkg.sv
// Purpose: types for the instruction decode subset
// Assumes: nothing beyond the defines header
// Notes: types only
package ids_pkg;
   // ==========================================
   // instruction operations
   typedef enum logic [3:0] {
      IDS_NOP = 4'h0,
      IDS_COPY = 4'h1,
      IDS_OR = 4'h2,
      IDS_LDLIT = 4'h3,
      IDS_STORE = 4'h4,
      IDS_RETI = 4'h5,
      IDS_OPTION = 4'h6,
      IDS_RETLIT = 4'h7,
      IDS_RET = 4'h8,
      IDS_ROTL = 4'h9,
      IDS_ROTR = 4'hA,
      IDS_SLEEP = 4'hB,
      IDS_SUBLIT = 4'hC,
      IDS_INCSZ = 4'hD
   } ids_op_t;
endpackage : ids_pkg

// >>> core/ids_phase_gen.sv
// Purpose: four-phase sequencer for one instruction cycle
// Assumes: single core clock
// Notes: each phase is one core clock, halted while asleep
`timescale 1ns/1ps
`include "ids_defines.svh"
module ids_phase_gen (
   input wire logic core_clk, // core clock
   input wire logic rst_n, // async reset, low
   input wire logic run, // advance phases
   output logic [1:0] phase, // current phase 0..3
   output logic last_phase // high in fourth phase
);
   logic [1:0] phase_reg;
   logic [1:0] phase_next;
   always_comb begin
      phase_next = phase_reg;
      if (run) begin
         phase_next = phase_reg + 2'h1;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= phase_next;
      end
   end
   assign phase = phase_reg;
   assign last_phase = run && (phase_reg == `IDS_PHASES);
endmodule : ids_phase_gen

// >>> core/ids_decode.sv
// Purpose: opcode classifier for the decode subset
// Assumes: 14-bit instruction word
// Notes: unknown words decode to nop
`timescale 1ns/1ps
`include "ids_defines.svh"
module ids_decode (
   input wire logic [13:0] instr, // instruction word
   output ids_pkg::ids_op_t op // decoded operation
);
   always_comb begin
      op = ids_pkg::IDS_NOP;
      if (instr == `IDS_W_RETI) begin
         op = ids_pkg::IDS_RETI;
      end else if (instr == `IDS_W_RET) begin
         op = ids_pkg::IDS_RET;
      end else if (instr == `IDS_W_OPTION) begin
         op = ids_pkg::IDS_OPTION;
      end else if (instr == `IDS_W_SLEEP) begin
         op = ids_pkg::IDS_SLEEP;
      end else if (instr[13:7] == 7'h01) begin
         op = ids_pkg::IDS_STORE;
      end else if (instr[13:12] == `IDS_OP_LIT_HI) begin
         if (instr[11:10] == `IDS_LIT_LOAD) begin
            op = ids_pkg::IDS_LDLIT;
         end else if (instr[11:10] == `IDS_LIT_RET) begin
            op = ids_pkg::IDS_RETLIT;
         end else if (instr[11:9] == `IDS_LIT_SUB3) begin
            op = ids_pkg::IDS_SUBLIT;
         end
      end else begin
         unique case (instr[13:8])
            `IDS_OP_COPY: op = ids_pkg::IDS_COPY;
            `IDS_OP_OR: op = ids_pkg::IDS_OR;
            `IDS_OP_ROTL: op = ids_pkg::IDS_ROTL;
            `IDS_OP_ROTR: op = ids_pkg::IDS_ROTR;
            `IDS_OP_INCSZ: op = ids_pkg::IDS_INCSZ;
            default: op = ids_pkg::IDS_NOP;
         endcase
      end
   end
endmodule : ids_decode

// >>> core/ids_core.sv
// Purpose: decode and execute for an instruction subset
// Assumes: file data returned combinationally for file_addr
// Notes: program counter and stack live outside; pops are pulses
//
// How it works
// - destination bit 0 writes accumulator, 1 writes file register
// - copy_file moves register to destination, updates zero flag
// - or_acc_into_file ORs accumulator with register, updates zero
// - load_literal_acc loads literal, status untouched
// - store_acc_file writes accumulator to register, no flags
// - four phases: decode, read, process, write
// - interrupt_return pops stack, sets global_irq_gate, two cycles
// - load-option copies accumulator into prescale_config_reg
// - return_literal loads literal and pops stack, two cycles
// - return pops stack, no flags, second cycle idle
// - rotate left through overflow bit
// - rotate right through overflow bit
// - sleep clears power_down_flag, sets expiry_status_bit
// - sleep clears watchdog_counter in fourth phase
// - after sleep execution halts until wake-up
// - literal_minus_acc: literal minus accumulator, sets carry, digit, zero
// - increment_skip_zero increments, skips next on zero result
`timescale 1ns/1ps
`include "ids_defines.svh"
module ids_core (
   input wire logic core_clk, // 50 MHz core clock
   input wire logic rst_n, // async reset, low
   input wire logic [13:0] instr, // fetched instruction word
   input wire logic [7:0] file_rdata, // addressed file data
   input wire logic wake, // wake-up event
   output logic [6:0] file_addr, // file register address
   output logic [7:0] file_wdata, // file write data
   output logic file_we, // file write strobe
   output logic [7:0] acc, // accumulator
   output logic carry_flag, // arith_overflow_bit
   output logic nibble_overflow_bit, // digit carry
   output logic zero_flag, // zero flag
   output logic power_down_flag, // cleared by sleep
   output logic expiry_status_bit, // set by sleep
   output logic global_irq_gate, // set by interrupt return
   output logic [7:0] prescale_config_reg, // option copy
   output logic stack_pop, // pop head into pc, pulse
   output logic fetch_next, // instruction cycle done, pulse
   output logic watchdog_clear, // watchdog_counter to 00h, pulse
   output logic asleep // oscillator halted
);
   // ==========================================
   // phase sequencing and decode
   logic [1:0] phase;
   logic last_phase;
   logic run;
   ids_pkg::ids_op_t op;
   ids_pkg::ids_op_t act_op;
   logic idle_reg;
   logic idle_next;
   logic asleep_reg;
   logic asleep_next;

   assign run = !asleep_reg;

   ids_phase_gen u_phase (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .run(run),
      .phase(phase),
      .last_phase(last_phase)
   );

   ids_decode u_dec (
      .instr(instr),
      .op(op)
   );

   assign act_op = idle_reg ? ids_pkg::IDS_NOP : op;

   // ==========================================
   // datapath
   logic [7:0] acc_reg;
   logic [7:0] acc_next;
   logic c_reg;
   logic c_next;
   logic nib_reg;
   logic nib_next;
   logic z_reg;
   logic z_next;
   logic pwr_down_reg;
   logic pwr_down_next;
   logic expiry_reg;
   logic expiry_next;
   logic irq_gate_reg;
   logic irq_gate_next;
   logic [7:0] opt_reg;
   logic [7:0] opt_next;
   logic [7:0] opnd_reg;
   logic [7:0] opnd_next;
   logic [7:0] res_reg;
   logic [7:0] res_next;
   logic [6:0] addr_reg;
   logic [6:0] addr_next;
   logic [7:0] wdata_reg;
   logic [7:0] wdata_next;
   logic we_reg;
   logic we_next;
   logic pop_reg;
   logic pop_next;
   logic fetch_reg;
   logic fetch_next_v;
   logic wdog_reg;
   logic wdog_next;
   logic dest_file;
   logic [8:0] diff;
   logic [4:0] ndiff;

   assign dest_file = instr[7];
   // two's complement literal minus accumulator
   assign diff = {1'b0, instr[7:0]} + {1'b0, ~acc_reg} + 9'h001;
   assign ndiff = {1'b0, instr[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;

   always_comb begin
      acc_next = acc_reg;
      c_next = c_reg;
      nib_next = nib_reg;
      z_next = z_reg;
      pwr_down_next = pwr_down_reg;
      expiry_next = expiry_reg;
      irq_gate_next = irq_gate_reg;
      opt_next = opt_reg;
      opnd_next = opnd_reg;
      res_next = res_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      we_next = 1'b0;
      pop_next = 1'b0;
      fetch_next_v = 1'b0;
      wdog_next = 1'b0;
      idle_next = idle_reg;
      asleep_next = asleep_reg;
      if (asleep_reg) begin
         if (wake) begin
            asleep_next = 1'b0;
         end
      end else begin
         unique case (phase)
            2'h0: begin
               addr_next = instr[6:0];
            end
            2'h1: begin
               opnd_next = file_rdata;
            end
            2'h2: begin
               unique case (act_op)
                  ids_pkg::IDS_COPY: res_next = opnd_reg;
                  ids_pkg::IDS_OR: res_next = opnd_reg | acc_reg;
                  ids_pkg::IDS_ROTL: res_next = {opnd_reg[6:0], c_reg};
                  ids_pkg::IDS_ROTR: res_next = {c_reg, opnd_reg[7:1]};
                  ids_pkg::IDS_INCSZ: res_next = opnd_reg + 8'h01;
                  default: res_next = opnd_reg;
               endcase
            end
            2'h3: begin
               fetch_next_v = 1'b1;
               idle_next = 1'b0;
               unique case (act_op)
                  ids_pkg::IDS_COPY, ids_pkg::IDS_OR,
                  ids_pkg::IDS_INCSZ: begin
                     if (dest_file) begin
                        we_next = 1'b1;
                        wdata_next = res_reg;
                     end else begin
                        acc_next = res_reg;
                     end
                     if (act_op != ids_pkg::IDS_INCSZ) begin
                        z_next = (res_reg == 8'h00);
                     end else begin
                        idle_next = (res_reg == 8'h00);
                     end
                  end
                  ids_pkg::IDS_ROTL, ids_pkg::IDS_ROTR: begin
                     if (dest_file) begin
                        we_next = 1'b1;
                        wdata_next = res_reg;
                     end else begin
                        acc_next = res_reg;
                     end
                     c_next = (act_op == ids_pkg::IDS_ROTL) ?
                        opnd_reg[7] : opnd_reg[0];
                  end
                  ids_pkg::IDS_LDLIT: acc_next = instr[7:0];
                  ids_pkg::IDS_STORE: begin
                     we_next = 1'b1;
                     wdata_next = acc_reg;
                  end
                  ids_pkg::IDS_RETI: begin
                     irq_gate_next = 1'b1;
                     pop_next = 1'b1;
                     idle_next = 1'b1;
                  end
                  ids_pkg::IDS_OPTION: opt_next = acc_reg;
                  ids_pkg::IDS_RETLIT: begin
                     acc_next = instr[7:0];
                     pop_next = 1'b1;
                     idle_next = 1'b1;
                  end
                  ids_pkg::IDS_RET: begin
                     pop_next = 1'b1;
                     idle_next = 1'b1;
                  end
                  ids_pkg::IDS_SLEEP: begin
                     pwr_down_next = 1'b0;
                     expiry_next = 1'b1;
                     wdog_next = 1'b1;
                     asleep_next = 1'b1;
                  end
                  ids_pkg::IDS_SUBLIT: begin
                     acc_next = diff[7:0];
                     c_next = diff[8];
                     nib_next = ndiff[4];
                     z_next = (diff[7:0] == 8'h00);
                  end
                  default: begin
                  end
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= `IDS_ACC_RST;
         c_reg <= 1'b0;
         nib_reg <= 1'b0;
         z_reg <= 1'b0;
         pwr_down_reg <= 1'b1;
         expiry_reg <= 1'b1;
         irq_gate_reg <= 1'b0;
         opt_reg <= 8'hFF;
         opnd_reg <= 8'h00;
         res_reg <= 8'h00;
         addr_reg <= 7'h00;
         wdata_reg <= 8'h00;
         we_reg <= 1'b0;
         pop_reg <= 1'b0;
         fetch_reg <= 1'b0;
         wdog_reg <= 1'b0;
         idle_reg <= 1'b0;
         asleep_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         c_reg <= c_next;
         nib_reg <= nib_next;
         z_reg <= z_next;
         pwr_down_reg <= pwr_down_next;
         expiry_reg <= expiry_next;
         irq_gate_reg <= irq_gate_next;
         opt_reg <= opt_next;
         opnd_reg <= opnd_next;
         res_reg <= res_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         we_reg <= we_next;
         pop_reg <= pop_next;
         fetch_reg <= fetch_next_v;
         wdog_reg <= wdog_next;
         idle_reg <= idle_next;
         asleep_reg <= asleep_next;
      end
   end

   assign file_addr = addr_reg;
   assign file_wdata = wdata_reg;
   assign file_we = we_reg;
   assign acc = acc_reg;
   assign carry_flag = c_reg;
   assign nibble_overflow_bit = nib_reg;
   assign zero_flag = z_reg;
   assign power_down_flag = pwr_down_reg;
   assign expiry_status_bit = expiry_reg;
   assign global_irq_gate = irq_gate_reg;
   assign prescale_config_reg = opt_reg;
   assign stack_pop = pop_reg;
   assign fetch_next = fetch_reg;
   assign watchdog_clear = wdog_reg;
   assign asleep = asleep_reg;

   // ==========================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_sleep_flags: assert property (
      run && phase == 2'h3 && act_op == ids_pkg::IDS_SLEEP
      |=> !power_down_flag && expiry_status_bit && asleep)
      else $error("sleep did not set status and halt");
   chk_sleep_wdt: assert property (
      run && phase == 2'h3 && act_op == ids_pkg::IDS_SLEEP
      |=> watchdog_clear)
      else $error("sleep did not clear watchdog");
   chk_halt_hold: assert property (
      asleep && !wake |=> asleep && $stable(phase))
      else $error("execution ran while asleep");
   chk_reti_gate: assert property (
      run && phase == 2'h3 && act_op == ids_pkg::IDS_RETI
      |=> global_irq_gate && stack_pop ##4 fetch_next && !stack_pop)
      else $error("interrupt return wrong");
   chk_pop_idle: assert property (
      stack_pop |-> idle_reg ##1 !file_we [*4])
      else $error("cycle after pop not idle");
   chk_ldlit_acc: assert property (
      run && phase == 2'h3 && act_op == ids_pkg::IDS_LDLIT
      |=> acc == $past(instr[7:0]) && $stable(zero_flag))
      else $error("literal load wrong");
   chk_store_write: assert property (
      run && phase == 2'h3 && act_op == ids_pkg::IDS_STORE
      |=> file_we && file_wdata == $past(acc) && $stable(carry_flag))
      else $error("store wrong");
   chk_option_copy: assert property (
      run && phase == 2'h3 && act_op == ids_pkg::IDS_OPTION
      |=> prescale_config_reg == $past(acc))
      else $error("option copy wrong");
   chk_sub_zero: assert property (
      run && phase == 2'h3 && act_op == ids_pkg::IDS_SUBLIT
      && instr[7:0] == acc |=> zero_flag && carry_flag && acc == 8'h00)
      else $error("subtract zero case wrong");
   chk_fetch_period: assert property (
      fetch_next |=> !fetch_next [*3])
      else $error("instruction cycle shorter than four phases");

   cov_sleep: cover property (watchdog_clear ##[1:20] !asleep);
   cov_skip: cover property (
      run && phase == 2'h3 && act_op == ids_pkg::IDS_INCSZ && res_reg == 0);
   cov_retlit: cover property (
      last_phase && act_op == ids_pkg::IDS_RETLIT);
endmodule : ids_core

// >>> testbench/ids_mem_model.sv
// Purpose: far-side model of file registers and the return stack
// Assumes: file data answered combinationally for file_addr
// Notes: stack contents are not kept; pops are only counted
`timescale 1ns/1ps
module ids_mem_model (
   input wire logic core_clk, // core clock
   input wire logic rst_n, // async reset, low
   input wire logic [6:0] file_addr, // register address
   input wire logic [7:0] file_wdata, // write data
   input wire logic file_we, // write strobe
   input wire logic stack_pop, // pop pulse
   output logic [7:0] file_rdata, // addressed data
   output int pop_count // pops seen since reset
);
   // ==========================================
   // storage, preloaded by the bench
   logic [7:0] mem [0:127];
   assign file_rdata = mem[file_addr];
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pop_count <= 0;
      end else begin
         if (file_we) begin
            mem[file_addr] <= file_wdata;
         end
         if (stack_pop) begin
            pop_count <= pop_count + 1;
         end
      end
   end
endmodule : ids_mem_model

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the decode subset
// Assumes: one instruction presented per fetch_next pulse
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module testbench;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic wake = 1'b0;
   logic [7:0] file_rdata, file_wdata, acc, prescale_config_reg;
   logic [6:0] file_addr;
   logic file_we, carry_flag, nibble_overflow_bit, zero_flag;
   logic power_down_flag, expiry_status_bit, global_irq_gate;
   logic stack_pop, fetch_next, watchdog_clear, asleep, wdog_seen;
   int pop_count;
   int err_count = 0;
   int num_checks = 0;
   always #10 core_clk = ~core_clk;
   ids_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .instr(instr),
      .file_rdata(file_rdata), .wake(wake), .file_addr(file_addr),
      .file_wdata(file_wdata), .file_we(file_we), .acc(acc),
      .carry_flag(carry_flag), .nibble_overflow_bit(nibble_overflow_bit),
      .zero_flag(zero_flag), .power_down_flag(power_down_flag),
      .expiry_status_bit(expiry_status_bit),
      .global_irq_gate(global_irq_gate),
      .prescale_config_reg(prescale_config_reg), .stack_pop(stack_pop),
      .fetch_next(fetch_next), .watchdog_clear(watchdog_clear),
      .asleep(asleep));
   ids_mem_model u_mem (.core_clk(core_clk), .rst_n(rst_n),
      .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
      .stack_pop(stack_pop), .file_rdata(file_rdata),
      .pop_count(pop_count));
   // ==========================================
   // reporting
   task automatic end_of_test();
      if (err_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chk1
   // a file write lands one edge after its commit; a pending one counts
   function automatic logic [7:0] landed(input logic [6:0] a);
      if (file_we === 1'b1 && file_addr === a) begin
         return file_wdata;
      end
      return u_mem.mem[a];
   endfunction : landed
   // ==========================================
   // instruction cycles
   // bounded wait: a stuck sequencer ends the run instead of hanging
   task automatic step(input logic [13:0] word, output int cyc);
      instr = word;
      cyc = 0;
      wdog_seen = 1'b0;
      do begin
         @(posedge core_clk);
         #1;
         cyc++;
         if (watchdog_clear === 1'b1) wdog_seen = 1'b1;
      end while (fetch_next !== 1'b1 && cyc < 40);
      if (cyc >= 40) begin
         err_count++;
         $display("[FAIL] %0t no fetch_next pulse", $time);
         end_of_test();
      end
   endtask : step
   task automatic run(input logic [13:0] word);
      int c;
      step(word, c);
      chk1(1'(c == 4), 1'b1, "phase count");
   endtask : run
   // ==========================================
   // scenarios
   task automatic t_reset();
      int c;
      chk8(acc, 8'h00, "acc reset");
      chk8(prescale_config_reg, 8'hFF, "option reset");
      chk1(power_down_flag, 1'b1, "power down reset");
      chk1(expiry_status_bit, 1'b1, "expiry reset");
      chk1(global_irq_gate, 1'b0, "irq gate reset");
      chk1(carry_flag, 1'b0, "carry reset");
      step(14'h0000, c);
   endtask : t_reset
   task automatic t_move();
      u_mem.mem[7'h21] = 8'h00;
      u_mem.mem[7'h22] = 8'h13;
      run(14'h3000);
      run(14'h0821);
      chk1(zero_flag, 1'b1, "copy zero");
      run(14'h335A);
      chk8(acc, 8'h5A, "literal");
      chk1(zero_flag, 1'b1, "literal keeps z");
      run(14'h00A0);
      chk8(landed(7'h20), 8'h5A, "store");
      chk1(zero_flag, 1'b1, "store keeps z");
      run(14'h04A1);
      chk8(landed(7'h21), 8'h5A, "or to file");
      chk1(zero_flag, 1'b0, "or zero");
      run(14'h0422);
      chk8(acc, 8'h5B, "or to acc");
      chk8(landed(7'h22), 8'h13, "or d0 file kept");
      run(14'h08A2);
      chk8(acc, 8'h5B, "copy d1 acc kept");
   endtask : t_move
   task automatic t_rotate();
      u_mem.mem[7'h23] = 8'hE6;
      run(14'h0D23);
      chk8(acc, 8'hCC, "rotate left");
      chk1(carry_flag, 1'b1, "rotate left carry");
      run(14'h0CA3);
      chk8(landed(7'h23), 8'hF3, "rotate right");
      chk1(carry_flag, 1'b0, "rotate right carry");
   endtask : t_rotate
   task automatic t_sub();
      logic [7:0] ks [4] = '{8'h02, 8'h02, 8'h02, 8'h10};
      logic [7:0] ws [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
      logic [7:0] r;
      for (int i = 0; i < 4; i++) begin
         r = ks[i] - ws[i];
         run({6'h30, ws[i]});
         run({6'h3C, ks[i]});
         chk8(acc, r, "subtract");
         chk1(carry_flag, 1'(ks[i] >= ws[i]), "sub carry");
         chk1(nibble_overflow_bit, 1'(ks[i][3:0] >= ws[i][3:0]),
              "sub digit carry");
         chk1(zero_flag, 1'(r == 8'h00), "sub zero");
      end
   endtask : t_sub
   task automatic t_option();
      run(14'h303C);
      run(14'h0062);
      chk8(prescale_config_reg, 8'h3C, "option copy");
   endtask : t_option
   // pops and the idle second cycle
   task automatic t_return();
      logic [13:0] ws [3] = '{14'h0009, 14'h3477, 14'h0008};
      int p;
      int c;
      for (int i = 0; i < 3; i++) begin
         run(14'h3011);
         p = pop_count;
         step(ws[i], c);
         step(14'h30EE, c);
         chk1(1'(c == 4), 1'b1, "idle cycle length");
         chk1(1'(pop_count == p + 1), 1'b1, "one pop");
         chk8(acc, (i == 1) ? 8'h77 : 8'h11, "return acc");
         chk1(global_irq_gate, 1'b1, "irq gate set");
      end
   endtask : t_return
   task automatic t_skip();
      int c;
      u_mem.mem[7'h24] = 8'hFE;
      u_mem.mem[7'h25] = 8'h10;
      run(14'h0F25);
      chk8(acc, 8'h11, "incr to acc");
      run(14'h0FA4);
      run(14'h3042);
      chk8(acc, 8'h42, "no skip");
      step(14'h0FA4, c);
      chk8(landed(7'h24), 8'h00, "incr wrap");
      step(14'h30EE, c);
      chk8(acc, 8'h42, "skipped word");
   endtask : t_skip
   task automatic t_sleep();
      int c;
      int n;
      logic z;
      logic cy;
      z = zero_flag;
      cy = carry_flag;
      n = 0;
      step(14'h0063, c);
      chk1(wdog_seen, 1'b1, "watchdog clear");
      chk1(power_down_flag, 1'b0, "power down cleared");
      chk1(expiry_status_bit, 1'b1, "expiry set");
      chk1(zero_flag, z, "sleep keeps z");
      chk1(carry_flag, cy, "sleep keeps c");
      instr = 14'h3055;
      repeat (10) begin
         @(posedge core_clk);
         #1;
         if (fetch_next === 1'b1) n++;
      end
      chk1(asleep, 1'b1, "halted");
      chk1(1'(n == 0), 1'b1, "no fetch asleep");
      chk8(acc, 8'h42, "acc held asleep");
      wake = 1'b1;
      @(posedge core_clk);
      #1;
      wake = 1'b0;
      step(14'h3055, c);
      chk8(acc, 8'h55, "runs after wake");
      chk1(asleep, 1'b0, "awake");
   endtask : t_sleep
   // ==========================================
   // main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_move();
      t_rotate();
      t_sub();
      t_option();
      t_return();
      t_skip();
      t_sleep();
      end_of_test();
   end
endmodule : testbench
